// ===== core/fault_error_log_recorder.sv
/*
 * Fault and data-error log recorder: a 50-entry ring in a byte-addressed
 * nonvolatile memory, a run-time sectors-read count, Avalon-MM registers.
 * Assumes the memory answers each request with a one-cycle nv_ack and that
 * event inputs are synchronous to sys_clk.
 */
//Function
//RQ1 - Full ring overwrites oldest, no fault
//RQ2 - Exactly fifty mixed entries
//RQ3 - Code 20H-3FH error, other nonzero fault
//RQ4 - Illegal pointer: flag corruption, clear log
//RQ5 - Pointer, then count, entries bytes 8-507
//RQ6 - Ten-byte data-error entry layout
//RQ7 - Ten-byte fault entry layout
//RQ8 - Codes 1-1FH never logged
//RQ9 - Data-error codes never fault entries
//RQ10 - Interface status plus vendor byte subranges
//RQ11 - Zero status bytes for 50H, B0H-DFH
//RQ12 - Formatter status and error for 70H-8FH
//RQ13 - Compressed interface status bit order
//RQ14 - Formatter status bit order
//RQ15 - Formatter error bit order
//RQ16 - Keep only low vendor status byte
//RQ17 - Physical seek: physical cylinders, MSB set
//RQ18 - Count run-time sectors only, one total
//RQ19 - Per-head value is total over heads
//RQ20 - Fold count on data error or flush
//RQ21 - Fold count on run-time log read
//RQ22 - Flush zeroes the volatile count
//RQ23 - Hold off host while logging, 100 ms
//RQ24 - Pointer advances one entry, wraps
`timescale 1ns/1ps
`include "fault_log_cfg.svh"

module fault_error_log_recorder
  import fault_log_pkg::*;
#(
  parameter int LOG_HOLD_CYC = `LOG_HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic evt_valid,
  input wire logic [7:0] evt_code,
  input wire logic [15:0] evt_cur_cyl,
  input wire logic [7:0] evt_cur_head,
  input wire logic [15:0] evt_tgt_cyl,
  input wire logic [7:0] evt_tgt_head,
  input wire logic [15:0] evt_phys_cyl,
  input wire logic [7:0] evt_phys_head,
  input wire logic [15:0] evt_phys_tgt_cyl,
  input wire logic evt_phys_seek,
  input wire logic [7:0] evt_sector,
  input wire logic [7:0] evt_err_byte,
  input wire logic [7:0] iface_status,
  input wire logic [15:0] vendor_word,
  input wire logic [7:0] fmt_status,
  input wire logic [7:0] fmt_error,
  output logic evt_ready,
  input wire logic sector_read,
  input wire logic runtime_cmd,
  output logic nv_req,
  output logic nv_we,
  output logic [8:0] nv_addr,
  output logic [7:0] nv_wdata,
  input wire logic [7:0] nv_rdata,
  input wire logic nv_ack
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release and status formatter

  logic rst_meta_r;
  logic rst_n_q;
  rec_regs_t s;
  rec_regs_t n;
  fmt_if fmt_bus ();

  // Two-flop release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_q <= rst_meta_r;
    end
  end

  // Status inputs are taken in the cycle of evt_valid
  assign fmt_bus.code = evt_code;
  assign fmt_bus.iface_status = iface_status; // RQ13
  assign fmt_bus.vendor_word = vendor_word;
  assign fmt_bus.fmt_status = fmt_status;
  assign fmt_bus.fmt_error = fmt_error;

  fault_status_fmt u_fmt (
    .f(fmt_bus)
  );

  // Legal pointer: the start of one of the fifty entry slots
  function automatic logic ptr_legal(input logic [8:0] p);
    logic [8:0] off;
    off = p - `REC_LOG_FIRST;
    return (p >= `REC_LOG_FIRST) && (p <= `REC_LOG_LAST_ENTRY) &&
           ((off % `REC_ENTRY_BYTES) == 9'h000);
  endfunction : ptr_legal

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  logic acc;
  logic done;
  logic cnt_inc;
  logic [8:0] addr;
  logic [7:0] wd;
  logic [79:0] ebytes;
  logic [47:0] cbytes;
  logic [47:0] div;
  logic [15:0] cyl_a;
  logic [15:0] cyl_b;

  always_comb begin
    n = s;
    done = 1'b0;
    cnt_inc = sector_read && runtime_cmd; // RQ18
    ebytes = s.entry << {s.idx[3:0], 3'b000};
    cbytes = s.nv_cnt >> {s.idx[2:0] - 3'h2, 3'b000};
    div = (s.heads == 4'h0) ? 48'h1 : {44'h0, s.heads};
    cyl_a = evt_phys_seek ? (evt_phys_cyl | `CYL_PHYS_FLAG) : evt_cur_cyl;
    cyl_b = evt_phys_seek ? (evt_phys_tgt_cyl | `CYL_PHYS_FLAG)
                          : evt_tgt_cyl; // RQ17

    // One total for all heads; the estimate divides it
    if (cnt_inc) begin
      n.ram_cnt = s.ram_cnt + 48'h1;
    end
    n.per_head = s.nv_cnt / div; // RQ19
    n.busy_cnt = (s.st == S_IDLE) ? 23'h0 : s.busy_cnt + 23'h1;

    // Byte address and data for the memory access of this state
    acc = (s.st != S_IDLE) && (s.st != S_CHECK);
    addr = (s.st == S_ENTW) ? s.ptr + s.idx : s.idx;
    wd = 8'h00;
    if (s.st == S_ENTW) begin
      wd = ebytes[79:72];
    end else if (s.st == S_PTRW) begin
      wd = (s.idx == `REC_PTR_ADDR) ? s.ptr[7:0] : {7'h00, s.ptr[8]};
    end else if (s.st == S_CNTW) begin
      wd = cbytes[7:0];
    end

    // Memory handshake: request held until acknowledged
    if (acc) begin
      if (!s.nv_req) begin
        n.nv_req = 1'b1;
        n.nv_we = (s.st != S_LOAD);
        n.nv_addr = addr;
        n.nv_wdata = wd;
      end else if (nv_ack) begin
        n.nv_req = 1'b0;
        done = 1'b1;
      end
    end

    // Register write takes effect at the edge with waitrequest low
    if (!s.waitreq && avs_write && avs_byteenable[0]) begin
      if (avs_address == `REG_CTRL) begin
        n.pend = s.pend | avs_writedata[2:0];
      end else if (avs_address == `REG_STATUS) begin
        if (avs_writedata[`STAT_CORRUPT]) n.corrupt = 1'b0;
        if (avs_writedata[`STAT_TMO]) n.tmo = 1'b0;
      end else if (avs_address == `REG_HEADS) begin
        n.heads = avs_writedata[3:0];
      end
    end

    // Sequencer
    case (s.st)
      S_LOAD: begin
        if (done) begin
          if (s.idx == `REC_PTR_ADDR) begin
            n.ptr = {s.ptr[8], nv_rdata};
          end else if (s.idx < `REC_CNT_ADDR) begin
            n.ptr = {nv_rdata[0], s.ptr[7:0]};
            n.ptr_bad = (nv_rdata[7:1] != 7'h00);
          end else begin
            n.nv_cnt = s.nv_cnt |
              (48'(nv_rdata) << {s.idx[2:0] - 3'h2, 3'b000}); // RQ5
          end
          n.idx = s.idx + 9'h001;
          if (s.idx == `REC_CNT_LAST) n.st = S_CHECK;
        end
      end
      S_CHECK: begin
        if (ptr_legal(s.ptr) && !s.ptr_bad) begin
          n.st = S_IDLE;
        end else begin
          n.corrupt = 1'b1; // RQ4
          n.ptr = `REC_LOG_FIRST;
          n.idx = `REC_LOG_FIRST;
          n.st = S_CLEAR;
        end
      end
      S_CLEAR: begin
        if (done) begin
          n.idx = s.idx + 9'h001;
          if (s.idx == `REC_LOG_END) begin
            n.idx = `REC_PTR_ADDR;
            n.st = S_PTRW;
          end
        end
      end
      S_IDLE: begin
        // Events come before pending host commands
        if (evt_valid && s.evt_rdy && fmt_bus.cls == CL_ERROR) begin
          n.entry = {evt_phys_cyl, evt_phys_head, evt_cur_cyl,
                     evt_cur_head, evt_sector, evt_code, evt_err_byte,
                     `ERR_FIRST_COUNT}; // RQ6
          n.fold_pend = 1'b1; // RQ20
          n.idx = 9'h000;
          n.st = S_ENTW;
        end else if (evt_valid && s.evt_rdy && fmt_bus.cls == CL_FAULT) begin
          n.entry = {cyl_a, evt_cur_head, cyl_b, evt_tgt_head, evt_sector,
                     evt_code, fmt_bus.first_fault_status_byte,
                     fmt_bus.second_fault_status_byte}; // RQ7
          n.fold_pend = 1'b0;
          n.idx = 9'h000;
          n.st = S_ENTW;
        end else if (s.pend[`CTRL_CLEAR]) begin
          n.pend[`CTRL_CLEAR] = 1'b0;
          n.ptr = `REC_LOG_FIRST;
          n.idx = `REC_LOG_FIRST;
          n.fold_pend = 1'b0;
          n.st = S_CLEAR;
        end else if (s.pend[`CTRL_FLUSH] || s.pend[`CTRL_RDLOG]) begin
          n.pend[`CTRL_FLUSH] = 1'b0;
          n.pend[`CTRL_RDLOG] = 1'b0;
          n.nv_cnt = s.nv_cnt + s.ram_cnt; // RQ21
          n.ram_cnt = cnt_inc ? 48'h1 : 48'h0; // RQ22
          n.idx = `REC_CNT_ADDR;
          n.st = S_CNTW;
        end
      end
      S_ENTW: begin
        if (done) begin
          n.idx = s.idx + 9'h001;
          if (s.idx == `REC_ENTRY_LAST) begin
            // Oldest slot is reused silently once the ring is full
            n.ptr = (s.ptr == `REC_LOG_LAST_ENTRY) ? `REC_LOG_FIRST
                  : s.ptr + `REC_ENTRY_BYTES; // RQ24 RQ1 RQ2
            n.idx = `REC_PTR_ADDR;
            n.st = S_PTRW;
          end
        end
      end
      S_PTRW: begin
        if (done) begin
          n.idx = s.idx + 9'h001;
          if (s.idx != `REC_PTR_ADDR) begin
            n.st = S_IDLE;
            if (s.fold_pend) begin
              n.fold_pend = 1'b0;
              n.nv_cnt = s.nv_cnt + s.ram_cnt; // RQ20
              n.ram_cnt = cnt_inc ? 48'h1 : 48'h0;
              n.idx = `REC_CNT_ADDR;
              n.st = S_CNTW;
            end
          end
        end
      end
      S_CNTW: begin
        if (done) begin
          n.idx = s.idx + 9'h001;
          if (s.idx == `REC_CNT_LAST) n.st = S_IDLE;
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase

    // A memory that never answers must not lock the host out forever
    if (s.st != S_IDLE && s.busy_cnt == 23'(LOG_HOLD_CYC - 1)) begin
      n.st = S_IDLE;
      n.nv_req = 1'b0;
      n.tmo = 1'b1;
    end

    // Host access answered only when idle with nothing queued
    n.waitreq = 1'b1;
    if (s.waitreq && (avs_read || avs_write) && s.st == S_IDLE &&
        s.pend == 3'h0) begin
      n.waitreq = 1'b0; // RQ23
      n.rdata = 32'h0000_0000;
      if (avs_address == `REG_STATUS) begin
        n.rdata = {7'h00, s.ptr, 13'h0000, s.tmo, s.corrupt, 1'b0};
      end else if (avs_address == `REG_HEADS) begin
        n.rdata = {28'h000_0000, s.heads};
      end else if (avs_address == `REG_NVCNT_LO) begin
        n.rdata = s.nv_cnt[31:0];
      end else if (avs_address == `REG_NVCNT_HI) begin
        n.rdata = {16'h0000, s.nv_cnt[47:32]};
      end else if (avs_address == `REG_PER_HEAD) begin
        n.rdata = s.per_head[31:0];
      end else if (avs_address == `REG_RAMCNT) begin
        n.rdata = s.ram_cnt[31:0];
      end
    end
    n.evt_rdy = (n.st == S_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s <= '0;
      s.st <= S_LOAD;
      s.heads <= `HEADS_RST;
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitreq;
  assign evt_ready = s.evt_rdy;
  assign nv_req = s.nv_req;
  assign nv_we = s.nv_we;
  assign nv_addr = s.nv_addr;
  assign nv_wdata = s.nv_wdata;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_q);

  AST_LOW_CODE_SKIP: assert property ( // RQ8
    (s.st == S_IDLE && evt_valid && s.evt_rdy && evt_code != 8'h00 &&
     evt_code < 8'h20) |=> s.st != S_ENTW)
    else $error("low subrange code started a log entry");
  AST_ERR_LAYOUT: assert property ( // RQ9
    ($rose(s.st == S_ENTW) && s.entry[23:16] >= 8'h20 &&
     s.entry[23:16] <= 8'h3F) |-> (s.entry[7:0] == 8'h01 && s.fold_pend))
    else $error("data error entry not in error format");
  AST_ZERO_STATUS: assert property ( // RQ11
    ($rose(s.st == S_ENTW) && s.entry[23:16] >= 8'hB0 &&
     s.entry[23:16] <= 8'hDF) |-> s.entry[15:0] == 16'h0000)
    else $error("status bytes not zero");
  AST_FMT_STATUS: assert property ( // RQ12
    (s.st == S_IDLE && evt_valid && s.evt_rdy && evt_code >= 8'h70 &&
     evt_code <= 8'h8F) |=>
      s.entry[15:0] == {$past(fmt_status), $past(fmt_error)})
    else $error("formatter registers not copied");
  AST_CODE_NONZERO: assert property ( // RQ3
    s.st == S_ENTW |-> s.entry[23:16] != 8'h00)
    else $error("reserved code written to log");
  AST_PTR_WRAP: assert property ( // RQ24
    (s.st == S_ENTW && n.st == S_PTRW) |=> s.ptr ==
      (($past(s.ptr) == 9'h1F2) ? 9'h008 : $past(s.ptr) + 9'h00A))
    else $error("ring pointer did not advance one entry");
  AST_PTR_LEGAL: assert property ( // RQ2
    s.st == S_IDLE |-> (s.ptr >= 9'h008 && s.ptr <= 9'h1F2))
    else $error("ring pointer outside entry area");
  AST_CORRUPT_CLEAR: assert property ( // RQ4
    (s.st == S_CHECK && !ptr_legal(s.ptr)) |=>
      (s.st == S_CLEAR && s.corrupt && s.idx == 9'h008))
    else $error("illegal pointer did not start log clear");
  AST_HOLD_HOST: assert property ( // RQ23
    (s.st != S_IDLE && $past(s.st != S_IDLE)) |-> s.waitreq)
    else $error("host answered while logging");
  AST_FLUSH_FOLD: assert property ( // RQ22
    (s.st == S_IDLE && !(evt_valid && s.evt_rdy) && s.pend == 3'h1) |=>
      (s.nv_cnt == $past(s.nv_cnt) + $past(s.ram_cnt) &&
       s.ram_cnt <= 48'h1))
    else $error("flush did not fold and zero the count");
  AST_NV_HOLD: assert property ( // RQ5
    (s.nv_req && !nv_ack && s.busy_cnt < 23'(LOG_HOLD_CYC - 2)) |=>
      (s.nv_req && $stable(s.nv_addr) && $stable(s.nv_wdata)))
    else $error("memory request dropped before ack");

  COV_CORRUPT: cover property (s.st == S_CHECK ##1 s.st == S_CLEAR);
  COV_WRAP: cover property (s.st == S_ENTW && n.st == S_PTRW &&
    s.ptr == 9'h1F2);
  COV_FAULT: cover property ($rose(s.st == S_ENTW) && !s.fold_pend);
  COV_FLUSH: cover property (s.st == S_CNTW ##1 s.st == S_IDLE);

endmodule : fault_error_log_recorder

// ===== core/fault_log_cfg.svh
/*
 * Constants of the fault and data-error log recorder: memory layout of the
 * nonvolatile log, code subranges, register map and timing counts.
 * Assumes a byte-addressed nonvolatile memory of at least 512 bytes.
 */
`ifndef FAULT_LOG_CFG_SVH
`define FAULT_LOG_CFG_SVH

// Nonvolatile memory layout (byte addresses)
`define REC_PTR_ADDR 9'h000
`define REC_CNT_ADDR 9'h002
`define REC_CNT_LAST 9'h007
`define REC_LOG_FIRST 9'h008
`define REC_LOG_LAST_ENTRY 9'h1F2
`define REC_LOG_END 9'h1FB
`define REC_ENTRY_BYTES 9'h00A
`define REC_ENTRY_LAST 9'h009
`define REC_ENTRIES 50

// Code subranges
`define CODE_RSV 8'h00
`define CODE_ERR_LO 8'h20
`define CODE_ERR_HI 8'h3F
`define CODE_Z1_LO 8'h50
`define CODE_Z1_HI 8'h5F
`define CODE_FMT_LO 8'h70
`define CODE_FMT_HI 8'h8F
`define CODE_Z2_LO 8'hB0
`define CODE_Z2_HI 8'hDF
`define CYL_PHYS_FLAG 16'h8000
`define ERR_FIRST_COUNT 8'h01

// Register byte offsets
`define REG_CTRL 5'h00
`define REG_STATUS 5'h04
`define REG_HEADS 5'h08
`define REG_NVCNT_LO 5'h0C
`define REG_NVCNT_HI 5'h10
`define REG_PER_HEAD 5'h14
`define REG_RAMCNT 5'h18

// Field positions
`define CTRL_FLUSH 0
`define CTRL_RDLOG 1
`define CTRL_CLEAR 2
`define STAT_CORRUPT 1
`define STAT_TMO 2
`define HEADS_RST 4'h1

// Timing
`define LOG_HOLD_MS 100
`define CLK_KHZ 50000
`define LOG_HOLD_CYC (`LOG_HOLD_MS * `CLK_KHZ)

`endif

// ===== core/fault_log_pkg.sv
/*
 * Types of the log recorder: sequencer states, code classes, state record.
 * Assumes fault_log_cfg.svh on the include path.
 */
`include "fault_log_cfg.svh"

package fault_log_pkg;

  typedef enum logic [2:0] {
    S_LOAD = 3'b000,
    S_CHECK = 3'b001,
    S_CLEAR = 3'b010,
    S_IDLE = 3'b011,
    S_ENTW = 3'b100,
    S_PTRW = 3'b101,
    S_CNTW = 3'b110
  } rec_state_t;

  typedef enum logic [1:0] {
    CL_NONE = 2'b00,
    CL_DROP = 2'b01,
    CL_ERROR = 2'b10,
    CL_FAULT = 2'b11
  } code_class_t;

  typedef struct packed {
    rec_state_t st;
    logic [8:0] ptr;
    logic ptr_bad;
    logic [8:0] idx;
    logic [79:0] entry;
    logic fold_pend;
    logic [47:0] nv_cnt;
    logic [47:0] ram_cnt;
    logic [47:0] per_head;
    logic [3:0] heads;
    logic [2:0] pend;
    logic corrupt;
    logic tmo;
    logic [22:0] busy_cnt;
    logic waitreq;
    logic [31:0] rdata;
    logic nv_req;
    logic nv_we;
    logic [8:0] nv_addr;
    logic [7:0] nv_wdata;
    logic evt_rdy;
  } rec_regs_t;

endpackage : fault_log_pkg

// ===== core/fmt_if.sv
/*
 * Carrier between the recorder and its status byte formatter.
 * Assumes fault_log_pkg compiled first.
 */
`timescale 1ns/1ps

interface fmt_if;
  import fault_log_pkg::*;
  logic [7:0] code;
  logic [7:0] iface_status;
  logic [15:0] vendor_word;
  logic [7:0] fmt_status;
  logic [7:0] fmt_error;
  logic [7:0] first_fault_status_byte;
  logic [7:0] second_fault_status_byte;
  code_class_t cls;
  modport fmt (input code, input iface_status, input vendor_word,
    input fmt_status, input fmt_error, output first_fault_status_byte,
    output second_fault_status_byte, output cls);
  modport user (output code, output iface_status, output vendor_word,
    output fmt_status, output fmt_error, input first_fault_status_byte,
    input second_fault_status_byte, input cls);
endinterface : fmt_if

// ===== core/fault_status_fmt.sv
/*
 * Classifies a log code and forms the two fault status bytes.
 * Purely combinational; assumes the caller samples its outputs.
 */
`timescale 1ns/1ps
`include "fault_log_cfg.svh"

module fault_status_fmt
  import fault_log_pkg::*;
(
  fmt_if.fmt f
);

  // Subrange decode of the code byte
  always_comb begin
    f.first_fault_status_byte = 8'h00;
    f.second_fault_status_byte = 8'h00;
    f.cls = CL_FAULT;
    if (f.code == `CODE_RSV) begin
      f.cls = CL_NONE; // RQ3
    end else if (f.code < `CODE_ERR_LO) begin
      f.cls = CL_DROP; // RQ8
    end else if (f.code <= `CODE_ERR_HI) begin
      f.cls = CL_ERROR; // RQ9
    end else if (f.code >= `CODE_FMT_LO && f.code <= `CODE_FMT_HI) begin
      f.first_fault_status_byte = f.fmt_status; // RQ12 RQ14
      f.second_fault_status_byte = f.fmt_error; // RQ12 RQ15
    end else if ((f.code >= `CODE_Z1_LO && f.code <= `CODE_Z1_HI) ||
                 (f.code >= `CODE_Z2_LO && f.code <= `CODE_Z2_HI)) begin
      f.first_fault_status_byte = 8'h00; // RQ11
    end else begin
      // Interface status bits keep their order
      f.first_fault_status_byte = f.iface_status; // RQ10
      f.second_fault_status_byte = f.vendor_word[7:0]; // RQ16
    end
  end

endmodule : fault_status_fmt

// ===== tb/nv_mem_model.sv
/*
 * Behavioural byte-wide nonvolatile log memory on the far side of the
 * recorder. Assumes one request at a time, held until nv_ack is seen.
 */
`timescale 1ns/1ps
module nv_mem_model (
  input wire logic sys_clk,
  input wire logic nv_req,
  input wire logic nv_we,
  input wire logic [8:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  input wire logic [1:0] lat,
  output logic [7:0] nv_rdata,
  output logic nv_ack,
  output int wr_cnt
);
  logic [7:0] mem [0:511];
  logic [1:0] wait_n;
  ////////////////////////////////////////////////////////////
  // Erased pointer and entries, blank count: pointer starts out illegal
  initial begin
    for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
    for (int i = 2; i < 8; i++) mem[i] = 8'h00;
    nv_ack = 1'b0;
    nv_rdata = 8'h00;
    wr_cnt = 0;
    wait_n = 2'h0;
  end
  // Answer after lat idle cycles; read bus churns outside acks
  always @(posedge sys_clk) begin
    if (nv_ack) begin
      nv_ack <= 1'b0;
      nv_rdata <= ~nv_rdata;
    end else if (nv_req && wait_n < lat) begin
      wait_n <= wait_n + 2'h1;
    end else if (nv_req) begin
      wait_n <= 2'h0;
      nv_ack <= 1'b1;
      if (nv_we) begin
        mem[nv_addr] <= nv_wdata;
        wr_cnt <= wr_cnt + 1;
      end else begin
        nv_rdata <= mem[nv_addr];
      end
    end else begin
      nv_rdata <= ~nv_rdata; // Stale data must not look valid
    end
  end
endmodule : nv_mem_model

// ===== tb/fault_error_log_recorder_tb.sv
/*
 * Self-checking bench of the log recorder: event table, count folds,
 * ring wrap and clearing, all through Avalon-MM and the memory model.
 * Assumes the design files and nv_mem_model are compiled before it.
 */
`timescale 1ns/1ps
`include "fault_log_cfg.svh"
module fault_error_log_recorder_tb;
  logic sys_clk = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic evt_valid = 1'b0, evt_phys_seek = 1'b0, sector_read = 1'b0;
  logic runtime_cmd = 1'b0, avs_waitrequest, evt_ready, nv_req, nv_we;
  logic nv_ack;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0] avs_byteenable = 4'hF;
  logic [7:0] evt_code = 8'h00, evt_sector = 8'h00, evt_err_byte = 8'h00;
  logic [7:0] evt_cur_head = 8'h11, evt_tgt_head = 8'h22;
  logic [7:0] evt_phys_head = 8'h44, iface_status = 8'h00;
  logic [7:0] fmt_status = 8'h00, fmt_error = 8'h00, nv_wdata, nv_rdata;
  logic [15:0] evt_cur_cyl = 16'h0, evt_tgt_cyl = 16'h0, vendor_word = 16'h0;
  logic [15:0] evt_phys_cyl = 16'h0, evt_phys_tgt_cyl = 16'h0;
  logic [8:0] nv_addr, exp_ptr = 9'h008;
  logic [1:0] lat = 2'h0;
  int wr_cnt, w, mismatches = 0, check_count = 0, n_ent = 0;
  // Kind in bits 10:8: 0 dropped, 1 error, 2 iface, 3 zero, 4 formatter
  logic [10:0] rows [19] = '{11'h005, 11'h01F, 11'h000, 11'h120, 11'h13F,
    11'h240, 11'h24F, 11'h260, 11'h26F, 11'h290, 11'h2AF, 11'h2E0,
    11'h2FF, 11'h350, 11'h35F, 11'h3B0, 11'h3DF, 11'h470, 11'h48F};

  fault_error_log_recorder #(.LOG_HOLD_CYC(2000)) fault_error_log_recorder_i (
    .sys_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .evt_valid, .evt_code,
    .evt_cur_cyl, .evt_cur_head, .evt_tgt_cyl, .evt_tgt_head, .evt_phys_cyl,
    .evt_phys_head, .evt_phys_tgt_cyl, .evt_phys_seek, .evt_sector,
    .evt_err_byte, .iface_status, .vendor_word, .fmt_status, .fmt_error,
    .evt_ready, .sector_read, .runtime_cmd, .nv_req, .nv_we, .nv_addr,
    .nv_wdata, .nv_rdata, .nv_ack);
  nv_mem_model nv_mem_model_i (.sys_clk, .nv_req, .nv_we, .nv_addr,
    .nv_wdata, .lat, .nv_rdata, .nv_ack, .wr_cnt);

  ////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task end_sim;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // Held until waitrequest is sampled low; released a cycle before reuse
  task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : av

  // Event fields derive from the code so entries of different codes differ
  task ev(input logic [7:0] c, input logic ph, input logic hold);
    while (evt_ready !== 1'b1) @(posedge sys_clk);
    evt_code <= c;
    evt_phys_seek <= ph;
    evt_cur_cyl <= {8'h12, c};
    evt_tgt_cyl <= {8'h23, ~c};
    evt_phys_cyl <= {8'h04, c};
    evt_phys_tgt_cyl <= {8'h05, ~c};
    evt_sector <= c ^ 8'h33;
    evt_err_byte <= c ^ 8'h77;
    iface_status <= c ^ 8'hA1;
    vendor_word <= {c, ~c};
    fmt_status <= c ^ 8'h5A;
    fmt_error <= c ^ 8'h6B;
    evt_valid <= 1'b1;
    @(posedge sys_clk);
    evt_valid <= 1'b0;
    if (hold) begin
      av(1'b0, `REG_STATUS, 32'h0);
      chk(evt_ready, 1'b1);
    end
    @(posedge sys_clk);
    while (evt_ready !== 1'b1) @(posedge sys_clk);
  endtask : ev

  task chk_ent(input logic [7:0] c, input logic [2:0] k, input logic ph);
    logic [15:0] cy, ty;
    logic [79:0] e;
    cy = ph ? {8'h84, c} : {8'h12, c};
    ty = ph ? {8'h85, ~c} : {8'h23, ~c};
    e = {cy, 8'h11, ty, 8'h22, c ^ 8'h33, c, c ^ 8'h5A, c ^ 8'h6B};
    if (k == 3'd1) e = {8'h04, c, 8'h44, 8'h12, c, 8'h11, c ^ 8'h33, c,
      c ^ 8'h77, 8'h01};
    if (k == 3'd2) e[15:0] = {c ^ 8'hA1, ~c};
    if (k == 3'd3) e[15:0] = 16'h0000;
    for (int i = 0; i < 10; i++)
      chk(nv_mem_model_i.mem[exp_ptr + i], e[79 - 8 * i -: 8]);
    exp_ptr = (exp_ptr == 9'h1F2) ? 9'h008 : exp_ptr + 9'h00A;
    n_ent++;
    chk({nv_mem_model_i.mem[1][0], nv_mem_model_i.mem[0]}, exp_ptr);
  endtask : chk_ent

  task chk_clear;
    exp_ptr = 9'h008;
    chk({nv_mem_model_i.mem[1][0], nv_mem_model_i.mem[0]}, exp_ptr);
    for (int i = 0; i < 50; i++)
      chk(nv_mem_model_i.mem[15 + 10 * i], 8'h00);
  endtask : chk_clear

  task sec(input int n, input logic rt);
    runtime_cmd <= rt;
    repeat (n) begin
      sector_read <= 1'b1;
      @(posedge sys_clk);
      sector_read <= 1'b0;
      @(posedge sys_clk);
    end
    runtime_cmd <= 1'b0;
  endtask : sec

  ////////////////////////////////////////////////////////////
  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    end_sim();
  end

  // Main sequence: reset checks, then the table, then hand-written cases
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    av(1'b0, `REG_STATUS, 32'h0);
    chk(rd[1], 1'b1);
    chk(rd[24:16], 9'h008);
    chk_clear();
    av(1'b0, `REG_HEADS, 32'h0);
    chk(rd, 32'h1);
    av(1'b0, 5'h1C, 32'h0);
    chk(rd, 32'h0);
    av(1'b1, `REG_STATUS, 32'h2);
    for (int i = 0; i < 19; i++) begin
      lat <= i[1:0];
      w = wr_cnt;
      ev(rows[i][7:0], 1'b0, i == 5);
      if (rows[i][10:8] == 3'd0) chk(wr_cnt, w);
      else chk_ent(rows[i][7:0], rows[i][10:8], 1'b0);
    end
    ev(8'h45, 1'b1, 1'b0);
    chk_ent(8'h45, 3'd2, 1'b1);
    sec(5, 1'b0);
    sec(8, 1'b1);
    av(1'b0, `REG_RAMCNT, 32'h0);
    chk(rd, 32'h8);
    av(1'b1, `REG_CTRL, 32'h1);
    av(1'b0, `REG_NVCNT_LO, 32'h0);
    chk(rd, 32'h8);
    chk(nv_mem_model_i.mem[2], 8'h08);
    av(1'b0, `REG_RAMCNT, 32'h0);
    chk(rd, 32'h0);
    sec(4, 1'b1);
    av(1'b1, `REG_CTRL, 32'h2);
    av(1'b0, `REG_NVCNT_LO, 32'h0);
    chk(rd, 32'hC);
    av(1'b1, `REG_HEADS, 32'h4);
    sec(3, 1'b1);
    ev(8'h2A, 1'b0, 1'b0);
    chk_ent(8'h2A, 3'd1, 1'b0);
    av(1'b0, `REG_NVCNT_LO, 32'h0);
    chk(rd, 32'hF);
    av(1'b0, `REG_PER_HEAD, 32'h0);
    chk(rd, 32'h3);
    while (n_ent < 52) begin
      ev(8'hC1, 1'b0, 1'b0);
      chk_ent(8'hC1, 3'd3, 1'b0);
    end
    av(1'b0, `REG_STATUS, 32'h0);
    chk(rd[1], 1'b0);
    chk(rd[24:16], exp_ptr);
    chk(rd[2], 1'b0);
    // A slow memory would outlast the short hold limit on a full clear
    lat <= 2'h0;
    av(1'b1, `REG_CTRL, 32'h4);
    av(1'b0, `REG_STATUS, 32'h0);
    chk_clear();
    end_sim();
  end
endmodule : fault_error_log_recorder_tb
